// ### hw/tcr_timer.sv
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
// How it works
// - capture channel 0 on the timer 0 input pin works only while capture0_enable is set.
// - with capture_auto_clear set, a capture also clears the 16-bit count to zero.
// - the clock-out pin toggles only while clock_out_enable is set and stays low otherwise.
// - in auto-reload mode down_count_enable with the trigger pin level picks count direction.
// - reload_capture_low takes the low count byte on capture and is the reload low byte.
// - reload_capture_high takes the high count byte on capture and is the reload high byte.
// - clearing run_control stops the count ticks; writes, trigger reloads and capture clears still load it.
// - capture_reload_select 1 captures on trigger falls; 0 reloads on overflow, or on trigger fall while down_count_enable is clear.
// - overflow_flag is set on overflow or down-count match and only software clears it.
// - counter_select 0 counts clock ticks, 1 counts falling edges of the count input pin.
module tcr_timer
    import tcr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic count_input_pin,
    input wire logic external_trigger_pin,
    input wire logic capture0_input_pin,
    output logic clock_out,
    // interrupt
    output logic irq
);
    import tcr_pkg::*;

    logic [7:0] mode_r;
    logic [7:0] ctrl_r;
    logic [15:0] count_r;
    logic [15:0] rcap_r;
    logic [7:0] ev_st_r;
    logic [7:0] ev_msk_r;
    logic clock_out_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;
    logic cnt_fall;
    logic trig_fall;
    logic cap0_fall;

    // decode a byte address into a register index match
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a[1:0] == 2'h0) && (a[11:2] == {2'h0, idx});
    endfunction

    tcr_edge u_cnt_edge (
        .clk(clk),
        .reset_n(reset_n),
        .pin(count_input_pin),
        .fall(cnt_fall)
    );

    tcr_edge u_trig_edge (
        .clk(clk),
        .reset_n(reset_n),
        .pin(external_trigger_pin),
        .fall(trig_fall)
    );

    tcr_edge u_cap0_edge (
        .clk(clk),
        .reset_n(reset_n),
        .pin(capture0_input_pin),
        .fall(cap0_fall)
    );

    // bus decode, taken in the access phase; every access answers in its second access cycle
    // writes land one edge before the master sees pready, so a master must never abort
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    assign acc = psel & penable & ~pready_r;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign mapped = hit(paddr, TCR_IDX_CTRL) | hit(paddr, TCR_IDX_MODE) |
                    hit(paddr, TCR_IDX_RCL) | hit(paddr, TCR_IDX_RCH) |
                    hit(paddr, TCR_IDX_CNTL) | hit(paddr, TCR_IDX_CNTH) |
                    hit(paddr, TCR_IDX_IRQ_ST) | hit(paddr, TCR_IDX_IRQ_MSK);

    // mode and control decode
    logic run;
    logic cap_mode;
    logic exen;
    logic tick;
    logic down;
    logic cap_trig;
    logic cap0;
    logic capture;
    logic reload_trig;
    logic at_top;
    logic at_bot;
    logic ovf_ev;
    logic sw_cnt_wr;
    assign run = ctrl_r[TCR_CTRL_RUN];
    assign cap_mode = ctrl_r[TCR_CTRL_CRSEL];
    assign exen = ctrl_r[TCR_CTRL_EXEN];
    assign tick = run & (ctrl_r[TCR_CTRL_CSEL] ? cnt_fall : 1'b1);
    // down only in auto-reload with down count enabled and trigger pin low
    assign down = ~cap_mode & mode_r[TCR_MODE_DOWN] & ~external_trigger_pin;
    assign cap_trig = cap_mode & exen & trig_fall;
    assign cap0 = mode_r[TCR_MODE_CAP0] & cap0_fall;
    assign capture = cap_trig | cap0;
    // trigger-driven reload applies only while the count is not also counting down
    assign reload_trig = ~cap_mode & exen & trig_fall & ~mode_r[TCR_MODE_DOWN];
    assign at_top = count_r == 16'hFFFF;
    assign at_bot = count_r == rcap_r;
    assign ovf_ev = tick & (down ? at_bot : at_top);
    assign sw_cnt_wr = wr & (hit(paddr, TCR_IDX_CNTL) | hit(paddr, TCR_IDX_CNTH));

    // counter: software write beats hardware so a loaded value is never lost to a tick
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_r <= TCR_RST16;
        end else if (sw_cnt_wr) begin
            if (hit(paddr, TCR_IDX_CNTL)) begin
                count_r[7:0] <= pwdata[7:0];
            end else begin
                count_r[15:8] <= pwdata[7:0];
            end
        end else if (capture && mode_r[TCR_MODE_ACLR]) begin
            count_r <= TCR_RST16;
        end else if (!cap_mode && (ovf_ev || reload_trig)) begin
            // down-count underflow wraps to all ones, otherwise reload
            count_r <= down ? 16'hFFFF : rcap_r;
        end else if (tick) begin
            count_r <= down ? count_r - 16'h0001 : count_r + 16'h0001;
        end
    end

    // capture/reload registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rcap_r <= TCR_RST16;
        end else if (capture) begin
            rcap_r <= count_r;
        end else if (wr && hit(paddr, TCR_IDX_RCL)) begin
            rcap_r[7:0] <= pwdata[7:0];
        end else if (wr && hit(paddr, TCR_IDX_RCH)) begin
            rcap_r[15:8] <= pwdata[7:0];
        end
    end

    // mode register; bit 2 is forced to one and reserved bits stay zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode_r <= TCR_MODE_RST;
        end else if (wr && hit(paddr, TCR_IDX_MODE)) begin
            mode_r <= (pwdata[7:0] & TCR_MODE_MASK) | TCR_MODE_RST;
        end
    end

    // control register; hardware flag sets win over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_r <= TCR_RST8;
        end else begin
            if (wr && hit(paddr, TCR_IDX_CTRL)) begin
                ctrl_r <= pwdata[7:0] & TCR_CTRL_MASK;
            end
            if (ovf_ev) begin
                ctrl_r[TCR_CTRL_OVF] <= 1'b1;
            end
            if (exen && trig_fall) begin
                ctrl_r[TCR_CTRL_EXF] <= 1'b1;
            end
        end
    end

    // clock out toggles on every overflow, held low while disabled
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clock_out_r <= 1'b0;
        end else if (!mode_r[TCR_MODE_OE]) begin
            clock_out_r <= 1'b0;
        end else if (ovf_ev) begin
            clock_out_r <= ~clock_out_r;
        end
    end

    // sticky event status; a read clears it, but a new event in that cycle survives
    logic [7:0] ev_now;
    assign ev_now = {5'h00, cap0, exen & trig_fall, ovf_ev};
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ev_st_r <= TCR_RST8;
        end else if (rd && hit(paddr, TCR_IDX_IRQ_ST)) begin
            ev_st_r <= ev_now;
        end else begin
            ev_st_r <= ev_st_r | ev_now;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ev_msk_r <= TCR_RST8;
        end else if (wr && hit(paddr, TCR_IDX_IRQ_MSK)) begin
            ev_msk_r <= pwdata[7:0] & TCR_EV_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(ev_st_r & ev_msk_r);
        end
    end

    // read mux
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit(paddr, TCR_IDX_CTRL)) rd_byte = ctrl_r;
        if (hit(paddr, TCR_IDX_MODE)) rd_byte = mode_r;
        if (hit(paddr, TCR_IDX_RCL)) rd_byte = rcap_r[7:0];
        if (hit(paddr, TCR_IDX_RCH)) rd_byte = rcap_r[15:8];
        if (hit(paddr, TCR_IDX_CNTL)) rd_byte = count_r[7:0];
        if (hit(paddr, TCR_IDX_CNTH)) rd_byte = count_r[15:8];
        if (hit(paddr, TCR_IDX_IRQ_ST)) rd_byte = ev_st_r;
        if (hit(paddr, TCR_IDX_IRQ_MSK)) rd_byte = ev_msk_r;
    end

    // bus answer: pready pulses one cycle after penable rises
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= acc;
            pslverr_r <= acc & ~mapped;
            prdata_r <= rd ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign clock_out = clock_out_r;
    assign irq = irq_r;

    // capture, clear and hold of the count
    a_cap_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (capture && mode_r[TCR_MODE_ACLR] && !sw_cnt_wr) |=> (count_r == 16'h0000))
        else $error("count not cleared on capture");
    a_cap_value: assert property (@(posedge clk) disable iff (!reset_n)
        capture |=> (rcap_r == $past(count_r)))
        else $error("capture value wrong");
    a_cap0_gate: assert property (@(posedge clk) disable iff (!reset_n)
        (cap0_fall && !mode_r[TCR_MODE_CAP0] && !cap_trig && !wr) |=> $stable(rcap_r))
        else $error("capture0 while disabled");
    a_clk_out_off: assert property (@(posedge clk) disable iff (!reset_n)
        !mode_r[TCR_MODE_OE] |=> !clock_out)
        else $error("clock out active while disabled");
    a_stop_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (!run && !sw_cnt_wr && !capture && !reload_trig) |=> $stable(count_r))
        else $error("count moved while stopped");
    a_ovf_set: assert property (@(posedge clk) disable iff (!reset_n)
        ovf_ev |=> ctrl_r[TCR_CTRL_OVF])
        else $error("overflow flag not set");
    a_up_reload: assert property (@(posedge clk) disable iff (!reset_n)
        (ovf_ev && !down && !cap_mode && !sw_cnt_wr && !(capture && mode_r[TCR_MODE_ACLR]))
        |=> (count_r == $past(rcap_r)))
        else $error("reload value wrong");
    a_mode_one: assert property (@(posedge clk) disable iff (!reset_n)
        mode_r[TCR_MODE_ONE] && (mode_r[7:5] == 3'h0))
        else $error("mode fixed bits wrong");
    a_down_dir: assert property (@(posedge clk) disable iff (!reset_n)
        (tick && down && !at_bot && !sw_cnt_wr && !capture)
        |=> (count_r == $past(count_r) - 16'h0001))
        else $error("down count wrong");

    // counting source and direction
    a_up_count: assert property (@(posedge clk) disable iff (!reset_n)
        (tick && !down && !at_top && !sw_cnt_wr && !capture && !reload_trig)
        |=> (count_r == $past(count_r) + 16'h0001))
        else $error("up count wrong");
    a_timer_tick: assert property (@(posedge clk) disable iff (!reset_n)
        (run && !ctrl_r[TCR_CTRL_CSEL] && !down && !at_top && !sw_cnt_wr && !capture &&
        !reload_trig) |=> (count_r == $past(count_r) + 16'h0001))
        else $error("timer tick missed");
    a_pin_wait: assert property (@(posedge clk) disable iff (!reset_n)
        (run && ctrl_r[TCR_CTRL_CSEL] && !cnt_fall && !sw_cnt_wr && !capture && !reload_trig)
        |=> $stable(count_r))
        else $error("count moved without a pin edge");
    a_trig_reload: assert property (@(posedge clk) disable iff (!reset_n)
        (reload_trig && !sw_cnt_wr && !(capture && mode_r[TCR_MODE_ACLR]))
        |=> (count_r == $past(rcap_r)))
        else $error("trigger reload wrong");

    // flags, status and interrupt
    a_ovf_keep: assert property (@(posedge clk) disable iff (!reset_n)
        (ctrl_r[TCR_CTRL_OVF] && !(wr && hit(paddr, TCR_IDX_CTRL))) |=> ctrl_r[TCR_CTRL_OVF])
        else $error("overflow flag lost");
    a_trig_flag: assert property (@(posedge clk) disable iff (!reset_n)
        (exen && trig_fall) |=> ctrl_r[TCR_CTRL_EXF])
        else $error("trigger flag not set");
    a_stat_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (ev_st_r[TCR_EV_OVF] && !(rd && hit(paddr, TCR_IDX_IRQ_ST))) |=> ev_st_r[TCR_EV_OVF])
        else $error("status bit lost");
    a_stat_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (rd && hit(paddr, TCR_IDX_IRQ_ST) && (ev_now == 8'h00)) |=> (ev_st_r == 8'h00))
        else $error("status not cleared by read");
    a_cap0_status: assert property (@(posedge clk) disable iff (!reset_n)
        cap0 |=> ev_st_r[TCR_EV_CAP0])
        else $error("capture0 event not recorded");
    a_irq_on: assert property (@(posedge clk) disable iff (!reset_n)
        ((ev_st_r & ev_msk_r) != 8'h00) |=> irq)
        else $error("interrupt missing");
    a_irq_off: assert property (@(posedge clk) disable iff (!reset_n)
        ((ev_st_r & ev_msk_r) == 8'h00) |=> !irq)
        else $error("interrupt without cause");
    a_clk_out_tog: assert property (@(posedge clk) disable iff (!reset_n)
        (mode_r[TCR_MODE_OE] && ovf_ev) |=> (clock_out != $past(clock_out)))
        else $error("clock out did not toggle");

    // registers and bus answer
    a_rcap_keep: assert property (@(posedge clk) disable iff (!reset_n)
        (!capture && !wr) |=> $stable(rcap_r))
        else $error("capture register moved");
    a_cnt_write: assert property (@(posedge clk) disable iff (!reset_n)
        (wr && hit(paddr, TCR_IDX_CNTL)) |=> (count_r[7:0] == $past(pwdata[7:0])))
        else $error("count low write lost");
    a_bus_ready: assert property (@(posedge clk) disable iff (!reset_n)
        (psel && penable && !pready) |=> pready)
        else $error("access not answered");
    a_ready_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        pready |=> !pready)
        else $error("ready held too long");
    a_bad_addr: assert property (@(posedge clk) disable iff (!reset_n)
        (psel && penable && !pready && !mapped) |=> pslverr)
        else $error("unmapped access without error");
endmodule

// ### hw/tcr_pkg.sv
package tcr_pkg;
    // register indices; each register is one aligned word at four times its index
    localparam logic [7:0] TCR_IDX_CTRL = 8'hC8;   // run/trigger/flag control
    localparam logic [7:0] TCR_IDX_MODE = 8'hC9;   // timer_mode_control
    localparam logic [7:0] TCR_IDX_RCL = 8'hCA;    // reload_capture_low
    localparam logic [7:0] TCR_IDX_RCH = 8'hCB;    // reload_capture_high
    localparam logic [7:0] TCR_IDX_CNTL = 8'hCC;   // count_low
    localparam logic [7:0] TCR_IDX_CNTH = 8'hCD;   // count_high
    localparam logic [7:0] TCR_IDX_IRQ_ST = 8'hD0; // sticky event status
    localparam logic [7:0] TCR_IDX_IRQ_MSK = 8'hD1; // interrupt mask
    // timer_mode_control bit positions
    localparam int TCR_MODE_DOWN = 0;
    localparam int TCR_MODE_OE = 1;
    localparam int TCR_MODE_ONE = 2;
    localparam int TCR_MODE_ACLR = 3;
    localparam int TCR_MODE_CAP0 = 4;
    localparam logic [7:0] TCR_MODE_MASK = 8'h1F;
    localparam logic [7:0] TCR_MODE_RST = 8'h04;
    // control register bit positions
    localparam int TCR_CTRL_CRSEL = 0;
    localparam int TCR_CTRL_CSEL = 1;
    localparam int TCR_CTRL_RUN = 2;
    localparam int TCR_CTRL_EXEN = 3;
    localparam int TCR_CTRL_EXF = 6;
    localparam int TCR_CTRL_OVF = 7;
    localparam logic [7:0] TCR_CTRL_MASK = 8'hCF;
    // interrupt status bit positions
    localparam int TCR_EV_OVF = 0;
    localparam int TCR_EV_TRIG = 1;
    localparam int TCR_EV_CAP0 = 2;
    localparam logic [7:0] TCR_EV_MASK = 8'h07;
    localparam logic [7:0] TCR_RST8 = 8'h00;
    localparam logic [15:0] TCR_RST16 = 16'h0000;
endpackage

// ### hw/tcr_edge.sv
`timescale 1ns/10ps
// registers a pin and reports its falling edge as a one-cycle pulse
module tcr_edge (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pin and result
    input wire logic pin,
    output logic fall
);
    logic last_r;

    // pin is synchronous, so one register is enough for edge detection
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            last_r <= 1'b1;
        end else begin
            last_r <= pin;
        end
    end

    assign fall = last_r & ~pin;
endmodule

// ### verif/tcr_pins.sv
`timescale 1ns/10ps
// far side pins: each request pulls its pin low for two cycles, one clean fall each while its pin idles high
module tcr_pins (
    // clock
    input wire logic clk,
    // requests from the bench
    input wire logic cnt_go,
    input wire logic cap_go,
    input wire logic trg_go,
    input wire logic trg_lvl,
    // pins toward the timer
    output logic count_input_pin,
    output logic capture0_input_pin,
    output logic external_trigger_pin
);
    logic [1:0] cnt_r = 2'h0;
    logic [1:0] cap_r = 2'h0;
    logic [1:0] trg_r = 2'h0;
    // low-time counters; two cycles so a registered input cannot miss the fall
    always @(posedge clk) begin
        cnt_r <= cnt_go ? 2'h2 : cnt_r - {1'b0, cnt_r != 2'h0};
        cap_r <= cap_go ? 2'h2 : cap_r - {1'b0, cap_r != 2'h0};
        trg_r <= trg_go ? 2'h2 : trg_r - {1'b0, trg_r != 2'h0};
    end
    assign count_input_pin = (cnt_r == 2'h0);
    assign capture0_input_pin = (cap_r == 2'h0);
    // trigger idles at the bench's level, which also steers the count direction
    assign external_trigger_pin = trg_lvl & (trg_r == 2'h0);
endmodule

// ### verif/timer2_capture_reload_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %0t got %0h expected %0h", $time, g, e); end end
module timer2_capture_reload_test;
    import tcr_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, clock_out, irq, cnt_pin, cap_pin, trg_pin;
    logic cnt_go = 1'b0;
    logic cap_go = 1'b0;
    logic trg_go = 1'b0;
    logic trg_lvl = 1'b1;
    int error_cnt = 0;
    int checks_done = 0;
    logic [9:0] note_q[$];
    logic [9:0] nt;
    logic [15:0] rv, cv, vv;
    int n;

    always #20 clk = ~clk;

    tcr_pins i_pins (.clk(clk), .cnt_go(cnt_go), .cap_go(cap_go), .trg_go(trg_go),
        .trg_lvl(trg_lvl), .count_input_pin(cnt_pin), .capture0_input_pin(cap_pin),
        .external_trigger_pin(trg_pin));
    tcr_timer i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_input_pin(cnt_pin), .external_trigger_pin(trg_pin),
        .capture0_input_pin(cap_pin), .clock_out(clock_out), .irq(irq));

    task automatic wrap_up;
        if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // one apb transfer; the expected answer is queued before the request leaves
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
        input logic c, input logic e);
        note_q.push_back({c, e, d});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin @(posedge clk); end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 1'b0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b0, idx, d, 1'b1, 1'b0);
    endtask
    // 16-bit values travel low byte first, no latching between the halves
    task automatic pair_wr(input logic [7:0] lo, input logic [15:0] v);
        wr(lo, v[7:0]);
        wr(lo + 8'h01, v[15:8]);
    endtask
    task automatic pair_chk(input logic [7:0] lo, input logic [15:0] v);
        rd(lo, v[7:0]);
        rd(lo + 8'h01, v[15:8]);
    endtask
    // one fall on a pin: 0 count, 1 capture 0, 2 trigger; then let it settle
    task automatic pulse(input int k);
        @(posedge clk);
        cnt_go <= (k == 0);
        cap_go <= (k == 1);
        trg_go <= (k == 2);
        @(posedge clk);
        cnt_go <= 1'b0;
        cap_go <= 1'b0;
        trg_go <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    // every answer takes the oldest note; values read here are those before the edge
    always @(posedge clk) begin
        if (pready === 1'b1 && note_q.size() > 0) begin
            nt = note_q.pop_front();
            if (nt[9]) `CHK(prdata[7:0], nt[7:0])
            `CHK(pslverr, nt[8])
        end
    end

    // generous bound: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h739B));
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rd(TCR_IDX_MODE, TCR_MODE_RST);
        pair_chk(TCR_IDX_CNTL, TCR_RST16);
        pair_chk(TCR_IDX_RCL, TCR_RST16);
        apb(1'b0, 8'hC0, 8'h00, 1'b1, 1'b1);
        apb(1'b1, 8'hCE, 8'h5A, 1'b0, 1'b1);
        wr(TCR_IDX_MODE, 8'hFF);
        rd(TCR_IDX_MODE, TCR_MODE_MASK);
        // overflow reloads from the capture pair, sets the flag, raises irq
        rv = {4'h1, 12'($urandom)};
        pair_wr(TCR_IDX_RCL, rv);
        wr(TCR_IDX_MODE, 8'h04);
        wr(TCR_IDX_IRQ_MSK, 8'h01);
        pair_wr(TCR_IDX_CNTL, 16'hFFFF);
        wr(TCR_IDX_CTRL, 8'h06);
        pulse(0);
        pair_chk(TCR_IDX_CNTL, rv);
        `CHK(irq, 1'b1)
        `CHK(clock_out, 1'b0)
        rd(TCR_IDX_IRQ_ST, 8'h01);
        rd(TCR_IDX_CTRL, 8'h86);
        `CHK(irq, 1'b0)
        wr(TCR_IDX_MODE, 8'h06);
        pair_wr(TCR_IDX_CNTL, 16'hFFFF);
        pulse(0);
        `CHK(clock_out, 1'b1)
        wr(TCR_IDX_CTRL, 8'h06);
        rd(TCR_IDX_CTRL, 8'h06);
        // a stopped counter ignores pin edges
        wr(TCR_IDX_CTRL, 8'h02);
        pulse(0);
        pair_chk(TCR_IDX_CNTL, rv);
        // direction comes from down_count_enable and the trigger level
        wr(TCR_IDX_MODE, 8'h05);
        trg_lvl <= 1'b0;
        pair_wr(TCR_IDX_CNTL, 16'h8005);
        wr(TCR_IDX_CTRL, 8'h06);
        pulse(0);
        pair_chk(TCR_IDX_CNTL, 16'h8004);
        trg_lvl <= 1'b1;
        pulse(0);
        pair_chk(TCR_IDX_CNTL, 16'h8005);
        // trigger capture with automatic clear
        cv = {1'b0, 15'($urandom)};
        n = 1 + $urandom % 3;
        wr(TCR_IDX_MODE, 8'h0C);
        pair_wr(TCR_IDX_CNTL, cv);
        wr(TCR_IDX_CTRL, 8'h0F);
        repeat (n) pulse(0);
        pulse(2);
        pair_chk(TCR_IDX_RCL, cv + 16'(n));
        pair_chk(TCR_IDX_CNTL, 16'h0000);
        // capture channel 0 acts only while enabled
        vv = 16'($urandom);
        wr(TCR_IDX_MODE, 8'h04);
        pair_wr(TCR_IDX_CNTL, vv);
        pulse(1);
        pair_chk(TCR_IDX_RCL, cv + 16'(n));
        wr(TCR_IDX_MODE, 8'h14);
        pulse(1);
        pair_chk(TCR_IDX_RCL, vv);
        // trigger fall reloads in auto-reload mode; every event left its status bit
        wr(TCR_IDX_MODE, 8'h04);
        wr(TCR_IDX_CTRL, 8'h0E);
        pair_wr(TCR_IDX_CNTL, ~vv);
        pulse(2);
        pair_chk(TCR_IDX_CNTL, vv);
        rd(TCR_IDX_IRQ_ST, 8'h07);
        // timer mode counts every clock: two ticks from 0xFFFE overflow and set the flag
        wr(TCR_IDX_CTRL, 8'h00);
        pair_wr(TCR_IDX_CNTL, 16'hFFFE);
        wr(TCR_IDX_CTRL, 8'h04);
        rd(TCR_IDX_CTRL, 8'h84);
        wrap_up();
    end
endmodule
